// ==== test/serial_output_chk.sv ====
`timescale 1ns/100ps
module serial_output_chk (
  input wire logic       i_clock,
  input wire logic       i_rstn,
  input wire logic       i_sync_clear_n,
  input wire logic       i_standby_we,
  input wire logic [7:0] i_standby_wdata,
  input wire logic [7:0] o_standby_rdata,
  input wire logic       o_serial_bit_clock,
  input wire logic       o_frame_sync_pin,
  input wire logic       o_reference_on,
  input wire logic       o_master_reference_on,
  input wire logic       o_sample_clock_buffer_on,
  input wire logic       o_lo_pump_output_oe,
  input wire logic       o_common_mode_output_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire [7:0] sb = o_standby_rdata;  // Short alias of the standby contents.
  a_ref_follow: assert property (o_reference_on == !sb[7])
    else $error("reference enable wrong");
  a_master_ref: assert property (o_master_reference_on == ((sb & 8'hfd) != 8'hfd))
    else $error("master reference wrong");
  a_clk_buffer: assert property (o_sample_clock_buffer_on == !(sb[4] && sb[0]))
    else $error("clock buffer wrong");
  a_pump_hiz: assert property (o_lo_pump_output_oe == !sb[6])
    else $error("pump enable wrong");
  a_vcm_hiz: assert property (o_common_mode_output_oe == !sb[0])
    else $error("common mode enable wrong");
  a_write_wakes: assert property (i_standby_we |=> sb == $past(i_standby_wdata))
    else $error("standby write lost");
  a_sync_parks: assert property (!i_sync_clear_n [*4] |-> o_serial_bit_clock && !o_frame_sync_pin)
    else $error("pins not parked");
  a_adc_freeze: assert property (sb[0] && $past(sb[0]) && $past(sb[0], 2) |-> $stable(o_serial_bit_clock))
    else $error("clock runs in standby");
  a_clk_resumes: assert property ($rose(i_sync_clear_n) && !sb[0] |-> ##[1:40] $changed(o_serial_bit_clock))
    else $error("clock did not resume");
  c_write: cover property (i_standby_we);
  c_parked: cover property (!i_sync_clear_n [*4]);
  c_awake: cover property (o_master_reference_on && !sb[0]);
endmodule
bind serial_output_sync_standby serial_output_chk u_serial_output_chk (.*);

// ==== test/serial_output_sync_standby_tb.sv ====
`timescale 1ns/100ps
module serial_output_sync_standby_tb;
  logic                         i_clock = 0, i_rstn = 0, i_sync_clear_n = 1, i_standby_we = 0;
  serial_port_pkg::serial_cfg_s i_cfg = '0;
  serial_port_pkg::sample_s     i_sample = '0;
  logic [11:0]                  i_decimation_factor = 12'd600;
  logic [6:0]                   nbits = 7'd32;
  logic [7:0]                   i_standby_wdata = 8'h00, o_standby_rdata;
  logic                         o_serial_bit_clock, o_frame_sync_pin, o_serial_data_out_a;
  logic                         o_data_valid, o_divisor_too_large, o_master_reference_on;
  logic                         o_sample_clock_buffer_on;
  logic [2:0]                   o_output_drive_field;
  logic [63:0]                  rx_frame;
  int                           rx_frames, mismatches = 0, n_checks = 0, seed = 32'h7596b3fe;
  always #50 i_clock = ~i_clock;
  serial_output_sync_standby #(.FLUSH_FRAMES(2)) u_serial_output_sync_standby (.i_clock, .i_rstn,
    .i_sync_clear_n, .i_cfg, .i_decimation_factor, .i_sample, .i_standby_we, .i_standby_wdata,
    .o_standby_rdata, .o_serial_bit_clock, .o_frame_sync_pin, .o_serial_data_out_a,
    .o_output_drive_field, .o_data_valid, .o_divisor_too_large, .o_reference_on(),
    .o_master_reference_on, .o_lo_synth_on(), .o_oscillator_on(), .o_clock_synth_on(),
    .o_gain_dac_on(), .o_front_end_on(), .o_converter_on(), .o_sample_clock_buffer_on,
    .o_lo_pump_output_oe(), .o_clock_pump_output_oe(), .o_common_mode_output_oe(),
    .o_gain_control_pos_oe(), .o_gain_control_neg_oe(), .o_front_end_pins_oe());
  serial_rx_model u_serial_rx_model (.i_clock, .i_bclk(o_serial_bit_clock),
    .i_fs(o_frame_sync_pin), .i_data(o_serial_data_out_a), .i_inv(i_cfg.invert_clock),
    .i_inv_fs(i_cfg.invert_sync), .i_len(nbits), .o_frame(rx_frame), .o_frames(rx_frames));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic sb_wr(input logic [7:0] v);
    i_standby_wdata = v;
    i_standby_we = 1;
    cyc(1);
    i_standby_we = 0;
  endtask
  task automatic wait_frame();
    int n0;
    n0 = rx_frames;
    for (int k = 0; k < 2000 && rx_frames == n0; k++) cyc(1);
    chk("frame_seen", 1, rx_frames != n0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Cuts a hang short well past the expected run time.
  initial begin
    #5000000;
    mismatches++;
    end_sim();
  end
  initial begin
    logic [7:0] v;
    logic [3:0] d;
    int         n;
    logic [63:0] exp;
    cyc(16);
    chk("drive_reset", 7, o_output_drive_field);
    i_rstn = 1;
    cyc(1);
    chk("sb_reset", 8'hff, o_standby_rdata);
    chk("master_off", 0, o_master_reference_on);
    // Standby corners first, then random words.
    for (int k = 0; k < 12; k++) begin
      v = (k < 2) ? (k ? 8'hfd : 8'h02) : 8'($random(seed));
      sb_wr(v);
      chk("sb_read", v, o_standby_rdata);
      chk("master_ref", (v & 8'hfd) != 8'hfd, o_master_reference_on);
      chk("clk_buf", !(v[4] && v[0]), o_sample_clock_buffer_on);
    end
    sb_wr(8'h00);
    // 16-bit frames under every polarity pair, then 24-bit frames with gain bytes.
    for (int m = 0; m < 5; m++) begin
      d = m ? 4'(2 + $unsigned($random(seed)) % 5) : 4'd6;
      i_cfg = '0;
      i_cfg.bit_rate_divisor = d;
      i_cfg.invert_clock = m[0];
      i_cfg.invert_sync = m[1];
      i_cfg.output_drive_field = 3'(m);
      i_cfg.word_width_select = (m == 4);
      i_cfg.embed_gain_option = (m == 4);
      nbits = (m == 4) ? 7'd64 : 7'd32;
      i_sample = {$random(seed), $random(seed)};
      i_sync_clear_n = 0;
      cyc(6);
      chk("parked", 2'b10, {o_serial_bit_clock, o_frame_sync_pin});
      chk("valid_clr", 0, o_data_valid);
      i_sync_clear_n = 1;
      repeat (3) wait_frame();
      exp = (m == 4) ? i_sample : {i_sample.i_word[23:8], i_sample.q_word[23:8], 32'h0};
      chk("frame_hi", exp[63:32], (m == 4) ? rx_frame[63:32] : rx_frame[31:0]);
      if (m == 4) chk("frame_lo", exp[31:0], rx_frame[31:0]);
      chk("valid", 1, o_data_valid);
      cyc(2 * d + 4);
      chk("idle_high", 1, o_serial_data_out_a);
      chk("drive", m, o_output_drive_field);
    end
    // Divisor limit on both sides of its boundary for two layouts.
    for (int k = 0; k < 4; k++) begin
      i_cfg.word_width_select = k[1];
      i_cfg.embed_gain_option = k[1];
      i_decimation_factor = k[1] ? 12'd600 : 12'd200;
      i_cfg.bit_rate_divisor = 4'((k[1] ? 9 : 6) + k[0]);
      cyc(1);
      chk("too_large", k[0], o_divisor_too_large);
    end
    sb_wr(8'h01);
    n = rx_frames;
    cyc(800);
    chk("frozen", 32'(n), 32'(rx_frames));
    end_sim();
  end
endmodule

// ==== test/serial_rx_model.sv ====
`timescale 1ns/100ps
module serial_rx_model (
  input  wire logic        i_clock,
  input  wire logic        i_bclk,
  input  wire logic        i_fs,
  input  wire logic        i_data,
  input  wire logic        i_inv,
  input  wire logic        i_inv_fs,
  input  wire logic [6:0]  i_len,
  output logic      [63:0] o_frame,
  output int               o_frames
);
  logic        last_q;       // Bit clock level one clock earlier.
  logic [63:0] sh_q;         // Bits of the frame in flight.
  int          cnt_q = -1;   // Bits taken, or -1 when waiting for sync.
  int          nfr_q = 0;    // Frames taken so far.
  assign o_frames = nfr_q;
  // sync then data.
  // Samples on the edge opposite to the one that launches the data.
  always @(posedge i_clock) begin
    last_q <= i_bclk;
    if (!(i_bclk ^ i_inv) && (last_q ^ i_inv)) begin
      if (i_fs ^ i_inv_fs) cnt_q <= 0;
      else if (cnt_q >= 0) begin
        sh_q <= {sh_q[62:0], i_data};
        cnt_q <= (cnt_q == int'(i_len) - 1) ? -1 : cnt_q + 1;
        if (cnt_q == int'(i_len) - 1) o_frame <= {sh_q[62:0], i_data};
        if (cnt_q == int'(i_len) - 1) nfr_q <= nfr_q + 1;
      end
    end
  end
endmodule

// ==== verilog/bit_clock_divider.sv ====
`timescale 1ns/100ps

module bit_clock_divider #(
  parameter int DIV_W = serial_port_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  // Control
  input  wire logic             i_restart,
  input  wire logic             i_hold,
  input  wire logic [DIV_W-1:0] i_divisor,
  // Bit timing
  output logic                  o_tick,
  output logic                  o_level
);

  // ------------------------------------------------------------
  // Period arithmetic
  // ------------------------------------------------------------
  logic [DIV_W-1:0] count_q;    // Position inside the bit period.
  logic [DIV_W-1:0] count_d;    // Next position.
  logic [DIV_W-1:0] effective;  // Divisor raised to the least usable value.
  logic [DIV_W-1:0] half;       // Cycles of the high phase.
  logic             last;       // Final cycle of the period.

  // A divisor below the minimum cannot be turned into a fabric clock.
  assign effective = (i_divisor < DIV_W'(serial_port_pkg::MIN_DIVISOR)) ?
                     DIV_W'(serial_port_pkg::MIN_DIVISOR) : i_divisor;
  // One extra bit keeps the largest divisor from wrapping to a zero high phase.
  assign half      = DIV_W'(({1'b0, effective} + 1'b1) >> 1);
  assign last      = (count_q >= effective - 1'b1);

  assign count_d = i_restart ? '0 :
                   i_hold    ? count_q :
                   last      ? '0 : count_q + 1'b1;

  assign o_tick  = (count_q == '0) && !i_hold && !i_restart;
  assign o_level = (count_q < half);

  // Period counter.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ==== verilog/serial_output_sync_standby.sv ====
`timescale 1ns/100ps

// How it works
// - Embedded sync frames keep ten idle bits.
// - Decimation factor comes from register seven.
// - Sync pulse one bit, then data rising.
// - I then Q, optional gain/status bytes.
// - Inverted polarity moves timing to falling edge.
// - Sync clears filter and port counters only.
// - Sync clears filter; valid after flush.
// - During sync, clock high, sync low.
// - Bit clock resumes within two periods.
// - Frame sync returns after decimation interval.
// - Standby register resets to all ones.
// - Writing zero wakes the matching block.
// - All blocks asleep sleeps master reference.
// - Bit seven stops reference; fixed bit map.
// - Converter standby halts filter, freezes outputs.
// - Synth, DAC, front end bits three-state pins.
// - Bit clock is modulator clock over divisor.
// - Unused frame tail filled with high bits.
// - Frame length set by width and options.

module serial_output_sync_standby #(
  parameter int DEC_W        = serial_port_pkg::DEC_W,
  parameter int FLUSH_FRAMES = serial_port_pkg::FLUSH_FRAMES
) (
  // Clock and reset
  input  wire logic                         i_clock,
  input  wire logic                         i_rstn,
  // Synchronisation pin, active low, asynchronous
  input  wire logic                         i_sync_clear_n,
  // Configuration and samples
  input  wire serial_port_pkg::serial_cfg_s i_cfg,
  input  wire logic [DEC_W-1:0]             i_decimation_factor,
  input  wire serial_port_pkg::sample_s     i_sample,
  // Standby register port
  input  wire logic                         i_standby_we,
  input  wire logic [7:0]                   i_standby_wdata,
  output logic [7:0]                        o_standby_rdata,
  // Serial port pins
  output logic                              o_serial_bit_clock,
  output logic                              o_frame_sync_pin,
  output logic                              o_serial_data_out_a,
  output logic [2:0]                        o_output_drive_field,
  // Port status
  output logic                              o_data_valid,
  output logic                              o_divisor_too_large,
  // Block power controls
  output logic                              o_reference_on,
  output logic                              o_master_reference_on,
  output logic                              o_lo_synth_on,
  output logic                              o_oscillator_on,
  output logic                              o_clock_synth_on,
  output logic                              o_gain_dac_on,
  output logic                              o_front_end_on,
  output logic                              o_converter_on,
  output logic                              o_sample_clock_buffer_on,
  // Three-state enables of analog pins
  output logic                              o_lo_pump_output_oe,
  output logic                              o_clock_pump_output_oe,
  output logic                              o_common_mode_output_oe,
  output logic                              o_gain_control_pos_oe,
  output logic                              o_gain_control_neg_oe,
  output logic                              o_front_end_pins_oe
);

  localparam int FW = serial_port_pkg::FRAME_W;

  // ------------------------------------------------------------
  // Synchroniser for the clear pin
  // ------------------------------------------------------------
  logic sync_meta_q;  // First stage, read only by the second.
  logic sync_q;       // Synchronised level, low while clearing.
  logic clearing;     // Clear is in force.

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_meta_q <= 1'b1;
      sync_q      <= 1'b1;
    end else begin
      sync_meta_q <= i_sync_clear_n;
      sync_q      <= sync_meta_q;
    end
  end

  assign clearing = !sync_q;

  // ------------------------------------------------------------
  // Standby register and power decode
  // ------------------------------------------------------------
  logic [7:0] standby_q;  // Standby bits, one per block.
  logic       adc_off;    // Converter asleep.

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      standby_q <= serial_port_pkg::STANDBY_RESET;
    end else if (i_standby_we) begin
      standby_q <= i_standby_wdata;
    end
  end

  assign o_standby_rdata = standby_q;
  assign adc_off         = standby_q[serial_port_pkg::SB_ADC];

  assign o_reference_on   = !standby_q[serial_port_pkg::SB_REF];
  assign o_lo_synth_on    = !standby_q[serial_port_pkg::SB_LO];
  assign o_oscillator_on  = !standby_q[serial_port_pkg::SB_OSC];
  assign o_clock_synth_on = !standby_q[serial_port_pkg::SB_CLKSYN];
  assign o_gain_dac_on    = !standby_q[serial_port_pkg::SB_GAIN];
  assign o_front_end_on   = !standby_q[serial_port_pkg::SB_FRONT];
  assign o_converter_on   = !adc_off;

  assign o_master_reference_on = ((standby_q & serial_port_pkg::STANDBY_BLOCK_MASK) !=
                                  serial_port_pkg::STANDBY_BLOCK_MASK);

  assign o_sample_clock_buffer_on = !(standby_q[serial_port_pkg::SB_CLKSYN] && adc_off);
  assign o_clock_pump_output_oe   = !standby_q[serial_port_pkg::SB_CLKSYN];

  assign o_lo_pump_output_oe   = !standby_q[serial_port_pkg::SB_LO];
  assign o_gain_control_pos_oe = !standby_q[serial_port_pkg::SB_GAIN];
  assign o_gain_control_neg_oe = !standby_q[serial_port_pkg::SB_GAIN];
  assign o_front_end_pins_oe   = !standby_q[serial_port_pkg::SB_FRONT];

  assign o_common_mode_output_oe = !adc_off;

  // ------------------------------------------------------------
  // Divisor limit check
  // ------------------------------------------------------------
  logic [serial_port_pkg::BITS_W-1:0] len_bits;  // Frame length for the options.
  logic [DEC_W+7:0]                   need;      // Divisor times frame length.

  assign len_bits = serial_port_pkg::frame_bits(i_cfg);

  assign need = (DEC_W+8)'(i_cfg.bit_rate_divisor) * (DEC_W+8)'(len_bits);
  assign o_divisor_too_large = (need > (DEC_W+8)'(i_decimation_factor));

  // ------------------------------------------------------------
  // Bit timing
  // ------------------------------------------------------------
  logic tick;   // Start of a bit period.
  logic level;  // Raw bit clock phase.

  bit_clock_divider #(
    .DIV_W (serial_port_pkg::DIV_W)
  ) u_divider (
    .i_clock   (i_clock),
    .i_rstn    (i_rstn),
    .i_restart (clearing),
    .i_hold    (adc_off),
    .i_divisor (i_cfg.bit_rate_divisor),
    .o_tick    (tick),
    .o_level   (level)
  );

  // ------------------------------------------------------------
  // Decimation interval
  // ------------------------------------------------------------
  logic [DEC_W-1:0] dec_count_q;  // Modulator clocks inside one output sample.
  logic             dec_wrap;     // A new output sample is ready.
  logic             pending_q;    // Sample waits for the next bit period.
  logic             load;         // Frame loads on this tick.
  logic             alt_q;        // Alternate byte selector.

  assign dec_wrap = !clearing && !adc_off &&
                    (dec_count_q >= i_decimation_factor - 1'b1);
  assign load     = pending_q && tick;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      dec_count_q <= '0;
    end else if (clearing || dec_wrap) begin
      dec_count_q <= '0;
    end else if (!adc_off) begin
      dec_count_q <= dec_count_q + 1'b1;
    end
  end

  // A new sample wins over the load that empties the slot.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pending_q <= 1'b0;
    end else if (clearing) begin
      pending_q <= 1'b0;
    end else if (dec_wrap) begin
      pending_q <= 1'b1;
    end else if (load) begin
      pending_q <= 1'b0;
    end
  end

  // Alternating gain and status byte, one per frame.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      alt_q <= 1'b0;
    end else if (clearing) begin
      alt_q <= 1'b0;
    end else if (load) begin
      alt_q <= !alt_q;
    end
  end

  // ------------------------------------------------------------
  // Frame assembly
  // ------------------------------------------------------------
  logic [FW-1:0] frame;  // Frame, first bit at the top, idle ones below.

  // Shifts a field of the given length in at the bottom.
  function automatic logic [FW-1:0] append(input logic [FW-1:0] acc,
                                           input logic [23:0]   val,
                                           input int            len);
    append = (acc << len) | FW'(val & ((24'h1 << len) - 24'h1));
  endfunction

  always_comb begin
    logic [FW-1:0] acc;
    int            used;
    acc  = '1;
    used = 0;
    if (i_cfg.embed_sync_option) begin
      acc  = append(acc, 24'h0, serial_port_pkg::START_BITS);
      used = used + serial_port_pkg::START_BITS;
    end
    if (i_cfg.word_width_select) begin
      acc  = append(acc, i_sample.i_word, serial_port_pkg::WORD24_BITS);
      acc  = append(acc, i_sample.q_word, serial_port_pkg::WORD24_BITS);
      used = used + 2 * serial_port_pkg::WORD24_BITS;
    end else begin
      acc  = append(acc, {8'h00, i_sample.i_word[23:8]}, serial_port_pkg::WORD16_BITS);
      acc  = append(acc, {8'h00, i_sample.q_word[23:8]}, serial_port_pkg::WORD16_BITS);
      used = used + 2 * serial_port_pkg::WORD16_BITS;
    end
    if (i_cfg.embed_gain_option && i_cfg.alternate_gain_bytes) begin
      acc  = append(acc, {16'h0000, alt_q ? i_sample.status_byte : i_sample.gain_byte},
                    serial_port_pkg::BYTE_BITS);
      used = used + serial_port_pkg::BYTE_BITS;
    end else if (i_cfg.embed_gain_option) begin
      acc  = append(acc, {16'h0000, i_sample.gain_byte}, serial_port_pkg::BYTE_BITS);
      acc  = append(acc, {16'h0000, i_sample.status_byte}, serial_port_pkg::BYTE_BITS);
      used = used + 2 * serial_port_pkg::BYTE_BITS;
    end
    frame = (acc << (FW - used)) | ((FW'(1) << (FW - used)) - FW'(1));
  end

  // ------------------------------------------------------------
  // Shifter and pins
  // ------------------------------------------------------------
  logic [FW-1:0] shift_q;    // Bits still to send.
  logic          fs_raw_q;   // Frame sync before polarity.
  logic          data_q;     // Serial data pin.
  logic          clk_pin_q;  // Bit clock pin.
  logic          fs_pin_q;   // Frame sync pin.

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_q  <= '1;
      fs_raw_q <= 1'b0;
      data_q   <= 1'b1;
    end else if (clearing) begin
      shift_q  <= '1;
      fs_raw_q <= 1'b0;
      data_q   <= 1'b1;
    end else if (load) begin
      shift_q  <= frame;
      fs_raw_q <= !i_cfg.embed_sync_option;
      data_q   <= 1'b1;
    end else if (tick) begin
      shift_q  <= {shift_q[FW-2:0], 1'b1};
      fs_raw_q <= 1'b0;
      data_q   <= shift_q[FW-1];
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_pin_q <= 1'b1;
      fs_pin_q  <= 1'b0;
    end else if (clearing) begin
      clk_pin_q <= 1'b1;
      fs_pin_q  <= 1'b0;
    end else if (!adc_off) begin
      clk_pin_q <= level ^ i_cfg.invert_clock;
      fs_pin_q  <= fs_raw_q ^ i_cfg.invert_sync;
    end
  end

  assign o_serial_bit_clock  = clk_pin_q;
  assign o_frame_sync_pin    = fs_pin_q;
  assign o_serial_data_out_a = data_q;

  // ------------------------------------------------------------
  // Drive strength and flush tracking
  // ------------------------------------------------------------
  logic [2:0] drive_q;   // Registered pad drive field.
  logic [3:0] flush_q;   // Frames sent since the last clear, held at FLUSH_FRAMES.

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      drive_q <= 3'h7;
    end else begin
      drive_q <= i_cfg.output_drive_field;
    end
  end

  assign o_output_drive_field = drive_q;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      flush_q <= '0;
    end else if (clearing) begin
      flush_q <= '0;
    end else if (load && (flush_q < 4'(FLUSH_FRAMES))) begin
      flush_q <= flush_q + 1'b1;
    end
  end

  assign o_data_valid = (flush_q >= 4'(FLUSH_FRAMES));

endmodule

// ==== verilog/serial_port_pkg.sv ====
package serial_port_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int DIV_W   = 4;   // Width of the bit-rate divisor field.
  localparam int DEC_W   = 12;  // Width of the decimation factor word.
  localparam int FRAME_W = 72;  // Width of the frame shift register.
  localparam int BITS_W  = 7;   // Width of a frame length in bits.

  // ------------------------------------------------------------
  // Register addresses and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DECIMATION_REG_ADDR = 8'h07;  // Source of the decimation factor.
  localparam logic [7:0] STANDBY_REG_ADDR    = 8'h00;  // Address of the standby register.
  localparam logic [7:0] STANDBY_RESET       = 8'hff;  // All blocks asleep at power-up.
  localparam logic [7:0] STANDBY_BLOCK_MASK  = 8'hfd;  // Bits that name real blocks.

  // ------------------------------------------------------------
  // Standby bit positions
  // ------------------------------------------------------------
  localparam int SB_REF    = 7;  // Voltage reference and biasing.
  localparam int SB_LO     = 6;  // Local-oscillator synthesizer.
  localparam int SB_OSC    = 5;  // Clock oscillator.
  localparam int SB_CLKSYN = 4;  // Clock synthesizer.
  localparam int SB_GAIN   = 3;  // Gain DAC.
  localparam int SB_FRONT  = 2;  // Front end.
  localparam int SB_ADC    = 0;  // Converter.

  // ------------------------------------------------------------
  // Frame layout constants
  // ------------------------------------------------------------
  localparam int SYNC_IDLE_BITS = 10;  // Least idle bits in an embedded-sync frame.
  localparam int START_BITS     = 1;   // Embedded start bit ahead of the data.
  localparam int WORD16_BITS    = 16;  // Narrow sample width.
  localparam int WORD24_BITS    = 24;  // Wide sample width.
  localparam int BYTE_BITS      = 8;   // One gain or status byte.
  localparam int MIN_DIVISOR    = 2;   // Least divisor the fabric can make a clock from.
  localparam int FLUSH_FRAMES   = 4;   // Frames discarded while the filter flushes.

  // Frame lengths for each option set (plain, embedded sync, gain, alternate).
  localparam logic [BITS_W-1:0] LEN16_PLAIN    = 7'd32;
  localparam logic [BITS_W-1:0] LEN16_SYNC     = 7'd49;
  localparam logic [BITS_W-1:0] LEN16_GAIN     = 7'd48;
  localparam logic [BITS_W-1:0] LEN16_ALT      = 7'd40;
  localparam logic [BITS_W-1:0] LEN16_GAIN_SYN = 7'd69;
  localparam logic [BITS_W-1:0] LEN16_ALT_SYN  = 7'd59;
  localparam logic [BITS_W-1:0] LEN24_PLAIN    = 7'd48;
  localparam logic [BITS_W-1:0] LEN24_SYNC     = 7'd69;
  localparam logic [BITS_W-1:0] LEN24_GAIN     = 7'd64;
  localparam logic [BITS_W-1:0] LEN24_ALT      = 7'd56;
  localparam logic [BITS_W-1:0] LEN24_GAIN_SYN = 7'd89;
  localparam logic [BITS_W-1:0] LEN24_ALT_SYN  = 7'd79;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic             embed_sync_option;     // Sync carried as a start bit in the data.
    logic             word_width_select;     // 1 selects 24-bit words.
    logic             embed_gain_option;     // Gain and status bytes follow the samples.
    logic             alternate_gain_bytes;  // One byte per frame, alternating.
    logic             invert_clock;          // Inverts the bit clock pin.
    logic             invert_sync;           // Inverts the frame sync pin.
    logic [2:0]       output_drive_field;    // Pad drive strength.
    logic [DIV_W-1:0] bit_rate_divisor;      // Modulator clocks per bit.
  } serial_cfg_s;

  typedef struct packed {
    logic [23:0] i_word;       // In-phase sample, left aligned.
    logic [23:0] q_word;       // Quadrature sample, left aligned.
    logic [7:0]  gain_byte;    // Gain information.
    logic [7:0]  status_byte;  // Status information.
  } sample_s;

  // Frame length for a given option set.
  function automatic logic [BITS_W-1:0] frame_bits(input serial_cfg_s cfg);
    logic [3:0] sel;
    sel = {cfg.word_width_select, cfg.embed_gain_option, cfg.embed_sync_option,
           cfg.alternate_gain_bytes & cfg.embed_gain_option};
    case (sel)
      4'h0, 4'h1: frame_bits = LEN16_PLAIN;
      4'h2, 4'h3: frame_bits = LEN16_SYNC;
      4'h4:       frame_bits = LEN16_GAIN;
      4'h5:       frame_bits = LEN16_ALT;
      4'h6:       frame_bits = LEN16_GAIN_SYN;
      4'h7:       frame_bits = LEN16_ALT_SYN;
      4'h8, 4'h9: frame_bits = LEN24_PLAIN;
      4'ha, 4'hb: frame_bits = LEN24_SYNC;
      4'hc:       frame_bits = LEN24_GAIN;
      4'hd:       frame_bits = LEN24_ALT;
      4'he:       frame_bits = LEN24_GAIN_SYN;
      default:    frame_bits = LEN24_ALT_SYN;
    endcase
  endfunction

endpackage
